/* File: rtl/uepc_pkg.sv */
// constants and types for the endpoint 1-3 control block
package uepc_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_FRAME_CTRL    = 8'h01;
  localparam logic [7:0] IDX_EP_INDEX      = 8'h0E;
  localparam logic [7:0] IDX_IN_CTRL_LOW   = 8'h11;
  localparam logic [7:0] IDX_IN_CTRL_HIGH  = 8'h12;
  localparam logic [7:0] IDX_OUT_CTRL_LOW  = 8'h14;
  localparam logic [7:0] IDX_OUT_CTRL_HIGH = 8'h15;
  localparam logic [7:0] IDX_OUT_CNT_LOW   = 8'h16;
  localparam logic [7:0] IDX_OUT_CNT_HIGH  = 8'h17;
  localparam logic [7:0] REG_RESET         = 8'h00;
  // in_endpoint_control_low fields
  localparam int IN_PRDY_BIT   = 0;
  localparam int IN_NEMPTY_BIT = 1;
  localparam int IN_UNDRN_BIT  = 2;
  localparam int IN_FLUSH_BIT  = 3;
  localparam int IN_SREQ_BIT   = 4;
  localparam int IN_SSENT_BIT  = 5;
  localparam int IN_CLRT_BIT   = 6;
  // in_endpoint_control_high fields
  localparam int CFG_SPLIT_BIT = 2;
  localparam int CFG_FTOG_BIT  = 3;
  localparam int CFG_DIR_BIT   = 5;
  localparam int CFG_ISO_BIT   = 6;
  localparam int CFG_DB_BIT    = 7;
  localparam logic [7:0] IN_CFG_MASK  = 8'hEC;
  localparam logic [7:0] OUT_CFG_MASK = 8'hC0;
  // out_endpoint_control_low fields
  localparam int OUT_PRDY_BIT  = 0;
  localparam int OUT_FULL_BIT  = 1;
  localparam int OUT_OVRN_BIT  = 2;
  localparam int OUT_DERR_BIT  = 3;
  localparam int OUT_FLUSH_BIT = 4;
  localparam int OUT_SREQ_BIT  = 5;
  localparam int OUT_SSENT_BIT = 6;
  localparam int OUT_CLRT_BIT  = 7;
  // frame control field
  localparam int FRM_DEFER_BIT = 0;
  // packet counts
  localparam int PKT_DEPTH = 2;
  localparam int CNT_W     = 10;
  localparam int CNT_LOW_W = 8;
  // handshake answer to the serial engine
  typedef enum logic [2:0] {
    HS_NONE  = 3'b000,
    HS_DATA  = 3'b001,
    HS_ZLP   = 3'b010,
    HS_NAK   = 3'b011,
    HS_STALL = 3'b100,
    HS_ACK   = 3'b101
  } uepc_hs_t;
endpackage

/* File: rtl/uepc_in_ep.sv */
// status and control of one IN endpoint
`timescale 1ns/1ps
module uepc_in_ep
#(
  parameter int DEPTH = uepc_pkg::PKT_DEPTH
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wr_lo,
  input  wire logic [7:0]        wdata,
  input  wire logic              db,
  input  wire logic              iso,
  input  wire logic              ftog,
  input  wire logic              defer,
  input  wire logic              token,
  input  wire logic              host_ack,
  input  wire logic              sof,
  output logic      [7:0]        rd_lo,
  output uepc_pkg::uepc_hs_t     hs,
  output logic                   toggle,
  output logic                   irq
);
  import uepc_pkg::*;
  initial if (DEPTH != 2) $error("uepc_in_ep: DEPTH must be 2");
  logic [1:0] cnt_reg;
  logic       sreq_reg;
  logic       ssent_reg;
  logic       undrn_reg;
  logic       tog_reg;
  logic       held_reg;
  logic       pend_reg;
  logic       irq_reg;
  logic [1:0] cap;
  logic       load;
  logic       flush;
  logic       stalling;
  logic       can_send;
  logic       sent;
  logic       prdy;
  assign cap      = db ? 2'(DEPTH) : 2'd1;
  assign load     = wr_lo & wdata[IN_PRDY_BIT] & (cnt_reg < cap);
  assign flush    = wr_lo & wdata[IN_FLUSH_BIT] & (cnt_reg != 2'd0);
  assign stalling = sreq_reg & ~iso;
  assign can_send = (cnt_reg != 2'd0) & ~held_reg;
  assign sent     = token & ~stalling & can_send;
  // ready reads one only while no slot is free, and never while withheld
  assign prdy     = ~held_reg & (db ? (cnt_reg == 2'd2) : (cnt_reg != 2'd0));
  always_comb
  begin
    if (!token)
      hs = HS_NONE;
    else if (stalling)
      hs = HS_STALL;
    else if (can_send)
      hs = HS_DATA;
    else if (iso)
      hs = HS_ZLP;
    else
      hs = HS_NAK;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_reg <= 2'd0;
    else if (token & stalling)
      cnt_reg <= 2'd0;
    else
      cnt_reg <= cnt_reg - 2'(sent | flush) + 2'(load);
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      held_reg <= 1'b0;
    else if (load & iso & defer)
      held_reg <= 1'b1;
    else if (sof)
      held_reg <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      sreq_reg <= 1'b0;
    else if (wr_lo)
      sreq_reg <= wdata[IN_SREQ_BIT];
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      ssent_reg <= 1'b0;
    else if (token & stalling)
      ssent_reg <= 1'b1;
    else if (wr_lo & ~wdata[IN_SSENT_BIT])
      ssent_reg <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      undrn_reg <= 1'b0;
    else if (token & ~stalling & ~can_send)
      undrn_reg <= 1'b1;
    else if (wr_lo & ~wdata[IN_UNDRN_BIT])
      undrn_reg <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      pend_reg <= 1'b0;
    else if (sent)
      pend_reg <= 1'b1;
    else if (host_ack | token)
      pend_reg <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      tog_reg <= 1'b0;
    else if (wr_lo & wdata[IN_CLRT_BIT])
      tog_reg <= 1'b0;
    else if (sent & ftog)
      tog_reg <= ~tog_reg;
    else if (host_ack & pend_reg & ~ftog)
      tog_reg <= ~tog_reg;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= sent | (token & stalling) | flush;
  end
  // clear-toggle and flush strobes read back as zero
  assign rd_lo  = {1'b0, 1'b0, ssent_reg, sreq_reg, 1'b0, undrn_reg,
                   cnt_reg != 2'd0, prdy};
  assign toggle = tog_reg;
  assign irq    = irq_reg;
endmodule // uepc_in_ep

/* File: rtl/uepc_out_ep.sv */
// status, control and length queue of one OUT endpoint
`timescale 1ns/1ps
module uepc_out_ep
#(
  parameter int DEPTH = uepc_pkg::PKT_DEPTH
)
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      wr_lo,
  input  wire logic [7:0]                wdata,
  input  wire logic                      db,
  input  wire logic                      iso,
  input  wire logic                      pkt,
  input  wire logic [uepc_pkg::CNT_W-1:0] len,
  input  wire logic                      crc_err,
  output logic      [7:0]                rd_lo,
  output logic      [uepc_pkg::CNT_W-1:0] count,
  output uepc_pkg::uepc_hs_t             hs,
  output logic                           toggle,
  output logic                           irq
);
  import uepc_pkg::*;
  initial if (DEPTH != 2) $error("uepc_out_ep: DEPTH must be 2");
  logic [CNT_W-1:0] len_mem [DEPTH];
  logic [DEPTH-1:0] err_mem;
  logic       wp_reg;
  logic       rp_reg;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       prdy_reg;
  logic       sreq_reg;
  logic       ssent_reg;
  logic       ovrn_reg;
  logic       tog_reg;
  logic       irq_reg;
  logic [1:0] cap;
  logic       stalling;
  logic       room;
  logic       accept;
  logic       pop;
  logic       full;
  assign cap      = db ? 2'(DEPTH) : 2'd1;
  assign stalling = sreq_reg & ~iso;
  assign room     = cnt_reg < cap;
  assign accept   = pkt & ~stalling & room & (iso | ~crc_err);
  assign pop      = wr_lo & (cnt_reg != 2'd0) &
                    ((prdy_reg & ~wdata[OUT_PRDY_BIT]) | wdata[OUT_FLUSH_BIT]);
  assign cnt_next = cnt_reg + 2'(accept) - 2'(pop);
  assign full     = db ? (cnt_reg == 2'd2) : (cnt_reg == 2'd1);
  always_comb
  begin
    if (!pkt || (crc_err && !iso))
      hs = HS_NONE;
    else if (stalling)
      hs = HS_STALL;
    else if (iso)
      hs = HS_NONE;
    else if (room)
      hs = HS_ACK;
    else
      hs = HS_NAK;
  end
  always_ff @(posedge clk)
  begin
    if (accept)
    begin
      len_mem[wp_reg] <= len;
      err_mem[wp_reg] <= crc_err;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'd0;
    end
    else
    begin
      wp_reg  <= wp_reg ^ accept;
      rp_reg  <= rp_reg ^ pop;
      cnt_reg <= cnt_next;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      prdy_reg <= 1'b0;
    else if (pop)
      prdy_reg <= cnt_next != 2'd0;
    else if (accept)
      prdy_reg <= 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      sreq_reg <= 1'b0;
    else if (wr_lo)
      sreq_reg <= wdata[OUT_SREQ_BIT];
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      ssent_reg <= 1'b0;
    else if (pkt & stalling)
      ssent_reg <= 1'b1;
    else if (wr_lo & ~wdata[OUT_SSENT_BIT])
      ssent_reg <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      ovrn_reg <= 1'b0;
    else if (pkt & iso & ~room)
      ovrn_reg <= 1'b1;
    else if (wr_lo & ~wdata[OUT_OVRN_BIT])
      ovrn_reg <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      tog_reg <= 1'b0;
    else if (wr_lo & wdata[OUT_CLRT_BIT])
      tog_reg <= 1'b0;
    else if (accept & ~iso)
      tog_reg <= ~tog_reg;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= (pop & (cnt_next != 2'd0)) | (accept & ~prdy_reg & ~pop) |
                 (pkt & stalling) | (pkt & iso & ~room);
  end
  // data error follows the packet at the head, so clearing ready clears it
  assign rd_lo  = {1'b0, ssent_reg, sreq_reg, 1'b0, prdy_reg & err_mem[rp_reg],
                   ovrn_reg, full, prdy_reg};
  // count reads zero while no packet is ready, so reset leaves no stale length
  assign count  = prdy_reg ? len_mem[rp_reg] : '0;
  assign toggle = tog_reg;
  assign irq    = irq_reg;
endmodule // uepc_out_ep

/* File: rtl/uepc_ctrl.sv */
// wishbone register file and link handling for endpoints 1 to 3
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - IN clear-toggle write zeroes toggle, reads zero
// - IN stall sent: flag, flush, ready cleared
// - IN stall request answers STALL, not iso
// - IN flush drops one packet, self clears
// - underrun on iso empty token or NAK
// - fifo not empty shows IN packets held
// - IN ready cleared on send or free slot
// - IN interrupt for transmitted packet, stall sent or flush
// - separate IN and OUT double buffer enables
// - per direction iso or bulk select bit
// - direction select applies only when unsplit
// - toggle advances on ACK, or always forced
// - split gives IN upper, OUT lower half; here split only lets both directions answer
// - OUT packet sets ready and interrupts
// - OUT stall request answers STALL, flags, interrupts
// - second buffered OUT packet re-sets ready, interrupts
// - iso OUT overrun drops packet, flags, interrupts
// - iso OUT bad CRC stored, error flag
// - OUT flush drops next packet, self clears
// - OUT full per double buffer setting
// - OUT clear-toggle write zeroes toggle, reads zero
// - OUT count low byte valid with ready
// - endpoint index selects visible register set
// - deferred iso IN packets wait for SOF
// - OUT count high two bits separately
module uepc_ctrl
#(
  parameter int NUM_EP = 3,
  parameter int ADDR_W = 10
)
(
  input  wire logic                         CLK,
  input  wire logic                         RST,
  input  wire logic                         CYC_I,
  input  wire logic                         STB_I,
  input  wire logic                         WE_I,
  input  wire logic [ADDR_W-1:0]            ADR_I,
  input  wire logic [3:0]                   SEL_I,
  input  wire logic [31:0]                  DAT_I,
  output logic      [31:0]                  DAT_O,
  output logic                              ACK_O,
  input  wire logic [1:0]                   TOKEN_EP,
  input  wire logic                         IN_TOKEN,
  input  wire logic                         IN_HOST_ACK,
  input  wire logic                         SOF,
  input  wire logic                         OUT_DATA_VALID,
  input  wire logic [uepc_pkg::CNT_W-1:0]   OUT_BYTE_COUNT,
  input  wire logic                         OUT_CRC_ERROR,
  output uepc_pkg::uepc_hs_t                IN_HANDSHAKE,
  output logic                              IN_DATA_TOGGLE,
  output uepc_pkg::uepc_hs_t                OUT_HANDSHAKE,
  output logic                              OUT_DATA_TOGGLE,
  output logic      [NUM_EP-1:0]            IN_IRQ,
  output logic      [NUM_EP-1:0]            OUT_IRQ
);
  import uepc_pkg::*;
  initial
  begin
    if (NUM_EP < 1 || NUM_EP > 3)
      $error("uepc_ctrl: NUM_EP must be 1 to 3");
    if (ADDR_W < 10)
      $error("uepc_ctrl: ADDR_W must be at least 10");
  end
  logic [1:0]         index_reg;
  logic               defer_reg;
  logic [7:0]         in_cfg_reg  [NUM_EP];
  logic [7:0]         out_cfg_reg [NUM_EP];
  logic               ack_reg;
  logic [31:0]        dat_reg;
  uepc_hs_t           in_hs_reg;
  uepc_hs_t           out_hs_reg;
  logic               in_tog_reg;
  logic               out_tog_reg;
  logic [NUM_EP-1:0]  in_irq_reg;
  logic [NUM_EP-1:0]  out_irq_reg;
  logic               req;
  logic               wr;
  logic [7:0]         ridx;
  logic [7:0]         wbyte;
  logic [7:0]         rbyte;
  logic               sel_ok;
  int                 sel_ep;
  int                 tok_ep;
  logic [NUM_EP-1:0]  in_wr_lo;
  logic [NUM_EP-1:0]  out_wr_lo;
  logic [NUM_EP-1:0]  in_active;
  logic [NUM_EP-1:0]  out_active;
  logic [NUM_EP-1:0]  in_tok;
  logic [NUM_EP-1:0]  out_pkt;
  logic [NUM_EP-1:0]  in_tog;
  logic [NUM_EP-1:0]  out_tog;
  logic [NUM_EP-1:0]  in_irq;
  logic [NUM_EP-1:0]  out_irq;
  logic [7:0]         in_rd   [NUM_EP];
  logic [7:0]         out_rd  [NUM_EP];
  logic [CNT_W-1:0]   out_cnt [NUM_EP];
  uepc_hs_t           in_hs   [NUM_EP];
  uepc_hs_t           out_hs  [NUM_EP];
  // bus decode: one access per request, answered the next edge
  assign req    = CYC_I & STB_I & ~ack_reg;
  assign wr     = req & WE_I & SEL_I[0];
  assign ridx   = ADR_I[9:2];
  assign wbyte  = DAT_I[7:0];
  assign sel_ep = int'(index_reg) - 1;
  assign sel_ok = (index_reg != 2'd0) && (int'(index_reg) <= NUM_EP);
  assign tok_ep = int'(TOKEN_EP) - 1;
  always_comb
  begin
    for (int e = 0; e < NUM_EP; e++)
    begin
      in_wr_lo[e]   = wr && sel_ok && (sel_ep == e) && (ridx == IDX_IN_CTRL_LOW);
      out_wr_lo[e]  = wr && sel_ok && (sel_ep == e) && (ridx == IDX_OUT_CTRL_LOW);
      // unsplit endpoints serve only the selected direction
      in_active[e]  = in_cfg_reg[e][CFG_SPLIT_BIT] | in_cfg_reg[e][CFG_DIR_BIT];
      out_active[e] = in_cfg_reg[e][CFG_SPLIT_BIT] | ~in_cfg_reg[e][CFG_DIR_BIT];
      in_tok[e]     = IN_TOKEN && (tok_ep == e) && in_active[e];
      out_pkt[e]    = OUT_DATA_VALID && (tok_ep == e) && out_active[e];
    end
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
      index_reg <= 2'd0;
    else if (wr && ridx == IDX_EP_INDEX)
      index_reg <= wbyte[1:0];
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
      defer_reg <= 1'b0;
    else if (wr && ridx == IDX_FRAME_CTRL)
      defer_reg <= wbyte[FRM_DEFER_BIT];
  end
  always_ff @(posedge CLK)
  begin
    for (int e = 0; e < NUM_EP; e++)
    begin
      if (RST)
      begin
        in_cfg_reg[e]  <= REG_RESET;
        out_cfg_reg[e] <= REG_RESET;
      end
      else if (wr && sel_ok && sel_ep == e)
      begin
        if (ridx == IDX_IN_CTRL_HIGH)
          in_cfg_reg[e] <= wbyte & IN_CFG_MASK;
        if (ridx == IDX_OUT_CTRL_HIGH)
          out_cfg_reg[e] <= wbyte & OUT_CFG_MASK;
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++)
    begin : g_ep
      uepc_in_ep #(.DEPTH(PKT_DEPTH)) u_in
      (
        .clk      (CLK),
        .rst      (RST),
        .wr_lo    (in_wr_lo[g]),
        .wdata    (wbyte),
        .db       (in_cfg_reg[g][CFG_DB_BIT]),
        .iso      (in_cfg_reg[g][CFG_ISO_BIT]),
        .ftog     (in_cfg_reg[g][CFG_FTOG_BIT]),
        .defer    (defer_reg),
        .token    (in_tok[g]),
        .host_ack (IN_HOST_ACK && (tok_ep == g)),
        .sof      (SOF),
        .rd_lo    (in_rd[g]),
        .hs       (in_hs[g]),
        .toggle   (in_tog[g]),
        .irq      (in_irq[g])
      );
      uepc_out_ep #(.DEPTH(PKT_DEPTH)) u_out
      (
        .clk      (CLK),
        .rst      (RST),
        .wr_lo    (out_wr_lo[g]),
        .wdata    (wbyte),
        .db       (out_cfg_reg[g][CFG_DB_BIT]),
        .iso      (out_cfg_reg[g][CFG_ISO_BIT]),
        .pkt      (out_pkt[g]),
        .len      (OUT_BYTE_COUNT),
        .crc_err  (OUT_CRC_ERROR),
        .rd_lo    (out_rd[g]),
        .count    (out_cnt[g]),
        .hs       (out_hs[g]),
        .toggle   (out_tog[g]),
        .irq      (out_irq[g])
      );
    end
  endgenerate
  // read mux; unmapped addresses and index zero read as zero
  always_comb
  begin
    rbyte = REG_RESET;
    case (ridx)
      IDX_FRAME_CTRL:
        rbyte = {7'd0, defer_reg};
      IDX_EP_INDEX:
        rbyte = {6'd0, index_reg};
      IDX_IN_CTRL_LOW:
        rbyte = sel_ok ? in_rd[sel_ep] : REG_RESET;
      IDX_IN_CTRL_HIGH:
        rbyte = sel_ok ? in_cfg_reg[sel_ep] : REG_RESET;
      IDX_OUT_CTRL_LOW:
        rbyte = sel_ok ? out_rd[sel_ep] : REG_RESET;
      IDX_OUT_CTRL_HIGH:
        rbyte = sel_ok ? out_cfg_reg[sel_ep] : REG_RESET;
      IDX_OUT_CNT_LOW:
        rbyte = sel_ok ? out_cnt[sel_ep][CNT_LOW_W-1:0] : REG_RESET;
      IDX_OUT_CNT_HIGH:
        rbyte = sel_ok ? {6'd0, out_cnt[sel_ep][CNT_W-1:CNT_LOW_W]} : REG_RESET;
      default:
        rbyte = REG_RESET;
    endcase
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= req;
      dat_reg <= (req && !WE_I) ? {24'h00_0000, rbyte} : 32'h0000_0000;
    end
  end
  // link answers registered one edge after the token or packet
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      in_hs_reg   <= HS_NONE;
      in_tog_reg  <= 1'b0;
      out_hs_reg  <= HS_NONE;
      out_tog_reg <= 1'b0;
    end
    else
    begin
      in_hs_reg   <= HS_NONE;
      out_hs_reg  <= HS_NONE;
      for (int e = 0; e < NUM_EP; e++)
      begin
        if (in_tok[e])
        begin
          in_hs_reg  <= in_hs[e];
          in_tog_reg <= in_tog[e];
        end
        if (out_pkt[e])
        begin
          out_hs_reg  <= out_hs[e];
          out_tog_reg <= out_tog[e];
        end
      end
    end
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      in_irq_reg  <= '0;
      out_irq_reg <= '0;
    end
    else
    begin
      in_irq_reg  <= in_irq;
      out_irq_reg <= out_irq;
    end
  end
  assign DAT_O           = dat_reg;
  assign ACK_O           = ack_reg;
  assign IN_HANDSHAKE    = in_hs_reg;
  assign IN_DATA_TOGGLE  = in_tog_reg;
  assign OUT_HANDSHAKE   = out_hs_reg;
  assign OUT_DATA_TOGGLE = out_tog_reg;
  assign IN_IRQ          = in_irq_reg;
  assign OUT_IRQ         = out_irq_reg;
endmodule // uepc_ctrl

/* File: testbench/uepc_ctrl_assertions.sv */
// port checker for the endpoint 1-3 control block
`timescale 1ns/1ps
module uepc_ctrl_assertions
#(
  parameter int NUM_EP = 3
)
(
  input wire logic              CLK,
  input wire logic              RST,
  input wire logic              CYC_I,
  input wire logic              STB_I,
  input wire logic              WE_I,
  input wire logic [31:0]       DAT_O,
  input wire logic              ACK_O,
  input wire logic              IN_TOKEN,
  input wire logic              OUT_DATA_VALID,
  input uepc_pkg::uepc_hs_t     IN_HANDSHAKE,
  input uepc_pkg::uepc_hs_t     OUT_HANDSHAKE,
  input wire logic [NUM_EP-1:0] IN_IRQ,
  input wire logic [NUM_EP-1:0] OUT_IRQ
);
  import uepc_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  wire req = CYC_I && STB_I;
  a_ack_answer: assert property (req && !ACK_O |=> ACK_O)
    else $error("request not acknowledged next cycle");
  a_ack_pulse: assert property ($rose(ACK_O) |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_idle_data: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("read data outside an answer");
  a_rd_upper: assert property (ACK_O |-> DAT_O[31:8] == 24'h0 && $past(req))
    else $error("bad read answer");
  a_in_cause: assert property (IN_HANDSHAKE != HS_NONE |-> $past(IN_TOKEN))
    else $error("IN answer without token");
  a_in_irq_src: assert property (|IN_IRQ |-> $past(IN_HANDSHAKE) inside {HS_DATA, HS_STALL}
    || $past(req && WE_I, 2))
    else $error("IN interrupt without cause");
  a_in_irq_set: assert property (IN_HANDSHAKE inside {HS_DATA, HS_STALL} |=> |IN_IRQ)
    else $error("IN send or stall without interrupt");
  a_in_nak_quiet: assert property (IN_HANDSHAKE inside {HS_NAK, HS_ZLP} |=>
    !(|IN_IRQ) || $past(req && WE_I, 2))
    else $error("IN interrupt without a transmitted packet");
  a_out_cause: assert property (OUT_HANDSHAKE != HS_NONE |-> $past(OUT_DATA_VALID))
    else $error("OUT answer without packet");
  a_out_irq_set: assert property (OUT_HANDSHAKE == HS_STALL |=> |OUT_IRQ)
    else $error("OUT stall without interrupt");
  a_out_irq_src: assert property (|OUT_IRQ |-> $past(OUT_DATA_VALID, 2) || $past(req && WE_I, 2))
    else $error("OUT interrupt without cause");
  cover property (IN_HANDSHAKE == HS_STALL);
  cover property (OUT_HANDSHAKE == HS_ACK);
  cover property (|OUT_IRQ && $past(WE_I));
endmodule // uepc_ctrl_assertions

bind uepc_ctrl uepc_ctrl_assertions #(.NUM_EP(NUM_EP)) chk_u (.*);

/* File: testbench/uepc_host_model.sv */
// host model issuing IN and OUT link events
`timescale 1ns/1ps
module uepc_host_model
(
  input  wire logic          clk,
  input  uepc_pkg::uepc_hs_t in_hs,
  input  uepc_pkg::uepc_hs_t out_hs,
  output logic [1:0]         token_ep,
  output logic               in_token,
  output logic               host_ack,
  output logic               sof,
  output logic               out_valid,
  output logic [9:0]         out_len,
  output logic               out_crc
);
  import uepc_pkg::*;
  initial
  begin
    {token_ep, in_token, host_ack, sof, out_valid, out_len, out_crc} = '0;
  end
  task automatic in_tok(input logic [1:0] ep, input logic ack, output uepc_hs_t h);
    @(posedge clk);
    token_ep <= ep;
    in_token <= 1'b1;
    @(posedge clk);
    in_token <= 1'b0;
    #1 h = in_hs;
    if (ack && h == HS_DATA)
    begin
      @(posedge clk);
      host_ack <= 1'b1;
      @(posedge clk);
      host_ack <= 1'b0;
    end
  endtask
  task automatic out_pkt(input logic [9:0] len, input logic crc, output uepc_hs_t h);
    @(posedge clk);
    token_ep <= 2'd1;
    out_len <= len;
    out_crc <= crc;
    out_valid <= 1'b1;
    @(posedge clk);
    out_valid <= 1'b0;
    // length is meaningless after the pulse, so show no stale value
    out_len <= ~len;
    #1 h = out_hs;
  endtask
  task automatic sof_pulse;
    @(posedge clk);
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
  endtask
endmodule // uepc_host_model

/* File: testbench/usb_endpoint_in_out_control_bench.sv */
// self-checking bench for the endpoint 1-3 control block
`timescale 1ns/1ps
module usb_endpoint_in_out_control_bench;
  import uepc_pkg::*;
  logic CLK = 1'b0, RST = 1'b1, CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
  logic [3:0] SEL_I = 4'hF;
  logic [9:0] ADR_I = '0;
  logic [31:0] DAT_I = '0, DAT_O;
  logic ACK_O, IN_TOKEN, IN_HOST_ACK, SOF, OUT_DATA_VALID, OUT_CRC_ERROR;
  logic IN_DATA_TOGGLE, OUT_DATA_TOGGLE;
  logic [1:0] TOKEN_EP;
  logic [9:0] OUT_BYTE_COUNT;
  logic [2:0] IN_IRQ, OUT_IRQ;
  uepc_hs_t IN_HANDSHAKE, OUT_HANDSHAKE;
  int n_mismatch = 0, samples_checked = 0;
  localparam logic [23:0] ROWS [10] = '{24'h0E0101, 24'h12FFEC, 24'h15FFC0, 24'h114000,
    24'h148000, 24'h142020, 24'h140000, 24'h128484, 24'h158080, 24'h305500};
  localparam logic [7:0] REGS [5] = '{8'h11, 8'h12, 8'h14, 8'h15, 8'h16};
  always #5 CLK = ~CLK;
  uepc_ctrl #(.NUM_EP(3), .ADDR_W(10)) dut_u (.*);
  uepc_host_model host_u (.clk(CLK), .in_hs(IN_HANDSHAKE), .out_hs(OUT_HANDSHAKE),
    .token_ep(TOKEN_EP), .in_token(IN_TOKEN), .host_ack(IN_HOST_ACK), .sof(SOF),
    .out_valid(OUT_DATA_VALID), .out_len(OUT_BYTE_COUNT), .out_crc(OUT_CRC_ERROR));
  task automatic chk(input string nm, input logic [7:0] got, e);
    samples_checked++;
    if (got !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one classic cycle; held until ack is seen at a rising edge, released there
  task automatic wb(input logic we, input logic [7:0] idx, d, output logic [7:0] q);
    int t = 0;
    @(posedge CLK);
    {CYC_I, STB_I, WE_I} <= {2'b11, we};
    ADR_I <= {idx, 2'b00};
    DAT_I <= {24'h0, d};
    do @(posedge CLK); while (ACK_O !== 1'b1 && ++t < 20);
    if (ACK_O !== 1'b1) n_mismatch++;
    q = DAT_O[7:0];
    {CYC_I, STB_I} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] idx, d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask
  task automatic rc(input logic [7:0] idx, e);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    chk("reg", q, e);
  endtask
  task automatic tk(input logic [1:0] ep, input logic ak, input uepc_hs_t e);
    uepc_hs_t h;
    host_u.in_tok(ep, ak, h);
    chk("in_hs", 8'(h), 8'(e));
  endtask
  task automatic op(input logic [9:0] len, input logic crc, input uepc_hs_t e);
    uepc_hs_t h;
    host_u.out_pkt(len, crc, h);
    chk("out_hs", 8'(h), 8'(e));
  endtask
  task automatic rst6;
    RST <= 1'b1;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    final_report;
  end
  initial
  begin
    rst6;
    foreach (ROWS[i])
    begin
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      rc(ROWS[i][23:16], ROWS[i][7:0]);
    end
    wr(8'h11, 8'h01);
    rc(8'h11, 8'h02);
    wr(8'h11, 8'h01);
    rc(8'h11, 8'h03);
    tk(2'd1, 1'b1, HS_DATA);
    rc(8'h11, 8'h02);
    wr(8'h11, 8'h40);
    tk(2'd1, 1'b0, HS_DATA);
    chk("tog", {7'h0, IN_DATA_TOGGLE}, 8'h00);
    wr(8'h12, 8'h8C);
    wr(8'h11, 8'h01);
    wr(8'h11, 8'h01);
    tk(2'd1, 1'b0, HS_DATA);
    tk(2'd1, 1'b0, HS_DATA);
    chk("tog", {7'h0, IN_DATA_TOGGLE}, 8'h01);
    tk(2'd1, 1'b0, HS_NAK);
    rc(8'h11, 8'h04);
    wr(8'h11, 8'h00);
    rc(8'h11, 8'h00);
    wr(8'h11, 8'h11);
    rc(8'h11, 8'h12);
    tk(2'd1, 1'b0, HS_STALL);
    rc(8'h11, 8'h30);
    wr(8'h11, 8'h00);
    rc(8'h11, 8'h00);
    wr(8'h11, 8'h01);
    wr(8'h11, 8'h01);
    wr(8'h11, 8'h08);
    rc(8'h11, 8'h02);
    wr(8'h11, 8'h08);
    rc(8'h11, 8'h00);
    wr(8'h12, 8'hC4);
    wr(8'h11, 8'h10);
    tk(2'd1, 1'b0, HS_ZLP);
    rc(8'h11, 8'h14);
    wr(8'h11, 8'h00);
    wr(8'h01, 8'h01);
    wr(8'h11, 8'h01);
    tk(2'd1, 1'b0, HS_ZLP);
    host_u.sof_pulse;
    tk(2'd1, 1'b0, HS_DATA);
    wr(8'h01, 8'h00);
    op(10'h123, 1'b0, HS_ACK);
    rc(8'h14, 8'h01);
    rc(8'h16, 8'h23);
    rc(8'h17, 8'h01);
    op(10'h045, 1'b0, HS_ACK);
    chk("out_tog", {7'h0, OUT_DATA_TOGGLE}, 8'h01);
    rc(8'h14, 8'h03);
    wr(8'h14, 8'h00);
    rc(8'h14, 8'h01);
    rc(8'h16, 8'h45);
    wr(8'h14, 8'h10);
    rc(8'h14, 8'h00);
    wr(8'h14, 8'h20);
    op(10'h001, 1'b0, HS_STALL);
    rc(8'h14, 8'h60);
    wr(8'h14, 8'h00);
    wr(8'h15, 8'h40);
    op(10'h008, 1'b1, HS_NONE);
    rc(8'h14, 8'h0B);
    op(10'h009, 1'b0, HS_NONE);
    rc(8'h14, 8'h0F);
    wr(8'h14, 8'h00);
    rc(8'h14, 8'h00);
    tk(2'd2, 1'b0, HS_NONE);
    wr(8'h0E, 8'h00);
    rc(8'h12, 8'h00);
    rst6;
    wr(8'h0E, 8'h01);
    foreach (REGS[i]) rc(REGS[i], 8'h00);
    final_report;
  end
endmodule // usb_endpoint_in_out_control_bench
